/* File: verilog/wclk_pkg.sv */
// Shared constants and types of the watch clock with alarms and stopwatch.
// Assumes a single 100 MHz system clock and an AXI4-Lite register bus.

package wclk_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned XTAL_HZ = 32768;
  localparam int unsigned TICK_HZ = 1;
  localparam int unsigned PRESCALE_DIV = XTAL_HZ / TICK_HZ;
  localparam int unsigned SWATCH_W = 16;

  // ----------------------------------------------------------------
  // Counter limits
  // ----------------------------------------------------------------
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [5:0] MIN_LAST = 6'h3B;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam logic [14:0] DAY_LAST = 15'h7FFF;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIME = 8'h04;
  localparam logic [7:0] OFS_ALARM_TOD = 8'h08;
  localparam logic [7:0] OFS_ALARM_DAY = 8'h0C;
  localparam logic [7:0] OFS_SWATCH = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Event bit positions, shared by CTRL (enable) and STATUS (pending)
  // ----------------------------------------------------------------
  localparam int unsigned EV_SEC = 0;
  localparam int unsigned EV_MIN = 1;
  localparam int unsigned EV_HOUR = 2;
  localparam int unsigned EV_DAY = 3;
  localparam int unsigned EV_ALM_TOD = 4;
  localparam int unsigned EV_ALM_DAY = 5;
  localparam int unsigned EV_SWATCH = 6;
  localparam int unsigned EV_N = 7;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [6:0] STATUS_RST = 7'h00;
  localparam logic [31:0] TIME_RST = 32'h0000_0000;
  localparam logic [31:0] ALARM_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Time layout, also the TIME / ALARM register layout
  typedef struct packed {
    logic [14:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } wclk_time_type;

  // AXI4-Lite request from the master
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } wclk_axil_req_type;

  // AXI4-Lite answer from the slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wclk_axil_rsp_type;

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] wclk_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

endpackage

/* File: verilog/wclk_prescaler.sv */
// Crystal prescaler: counts crystal edges down to the one-second tick.
// Assumes the crystal level arrives asynchronously and is far slower than clk.

`timescale 1ns/10ps

module wclk_prescaler
  import wclk_pkg::*;
#(
  parameter int unsigned DIV = PRESCALE_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Crystal level from the pin
  input wire logic xtal_in,
  // One-cycle tick per DIV crystal periods
  output logic tick
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DIV < 2 || DIV > 65536) begin : g_bad_div
    $error("wclk_prescaler: DIV out of range");
  end

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic [15:0] cnt;
    logic tick;
  } wclk_pre_state_type;

  localparam logic [15:0] CNT_LAST = 16'(DIV - 1);

  wclk_pre_state_type s_q, s_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Edge detect reads only the second and third stages, never sync1
  always_comb begin
    s_d = s_q;
    s_d.sync1 = xtal_in;
    s_d.sync2 = s_q.sync1;
    s_d.last = s_q.sync2;
    s_d.tick = 1'b0;
    if (s_q.sync2 && !s_q.last) begin
      if (s_q.cnt == CNT_LAST) begin
        s_d.cnt = 16'h0000;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

/* File: verilog/wclk_wrap_counter.sv */
// Wrapping counter with load and a same-cycle carry for cascading.
// Assumes step is a one-cycle pulse; load takes priority over step.

`timescale 1ns/10ps

module wclk_wrap_counter #(
  parameter int unsigned W = 6,
  parameter logic [W-1:0] LAST = W'(59)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic step,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Count and carry
  output logic [W-1:0] count,
  output logic carry
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (W < 1 || W > 31) begin : g_bad_w
    $error("wclk_wrap_counter: W out of range");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } wclk_cnt_state_type;

  wclk_cnt_state_type s_q, s_d;

  // Carry is combinational so the whole chain rolls over in one edge
  assign carry = step && !load && (s_q.cnt == LAST);

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = load_val;
    end else if (step) begin
      s_d.cnt = carry ? '0 : s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;

endmodule

/* File: verilog/wclk_top.sv */
// Watch clock: time of day and day count, two alarms, stopwatch, events.
// Assumes an AXI4-Lite master on clk and a crystal level on xtal_in.

`timescale 1ns/10ps

module wclk_top
  import wclk_pkg::*;
#(
  parameter int unsigned PRESCALE = PRESCALE_DIV,
  parameter int unsigned SW_W = SWATCH_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Crystal level
  input wire logic xtal_in,
  // Register bus
  input wire wclk_axil_req_type axil_req,
  output wclk_axil_rsp_type axil_rsp,
  // Interrupt and wakeup
  output logic irq,
  output logic wake_req,
  output logic deep_sleep_exit,
  output logic regulator_wake
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (SW_W < 1 || SW_W > 32) begin : g_bad_sw
    $error("wclk_top: SW_W out of range");
  end

  typedef struct packed {
    // Bus slave
    logic aw_full;
    logic [7:0] aw_addr;
    logic awready;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Registers
    logic [EV_N-1:0] ctrl;
    wclk_time_type alarm_tod;
    wclk_time_type alarm_day;
    logic [SW_W-1:0] sw_cnt;
    logic sw_run;
    logic [EV_N-1:0] pending;
    logic tick_dly;
    // Outputs
    logic irq;
    logic wake;
    logic deep;
    logic regul;
  } wclk_top_state_type;

  wclk_top_state_type s_q, s_d;

  logic tick;
  logic sec_carry, min_carry, hour_carry;
  logic time_load;
  // A net, since four counter instances each drive one field of it
  wire wclk_time_type time_now;
  wclk_time_type time_load_val;

  // ----------------------------------------------------------------
  // Tick and time counters
  // ----------------------------------------------------------------
  wclk_prescaler #(
    .DIV(PRESCALE)
  ) u_pre (
    .clk(clk),
    .rstn(rstn),
    .xtal_in(xtal_in),
    .tick(tick)
  );

  // Seconds, minutes, hours, days cascade through same-cycle carries
  wclk_wrap_counter #(.W(6), .LAST(SEC_LAST)) u_sec (
    .clk(clk),
    .rstn(rstn),
    .step(tick),
    .load(time_load),
    .load_val(time_load_val.sec),
    .count(time_now.sec),
    .carry(sec_carry)
  );

  wclk_wrap_counter #(.W(6), .LAST(MIN_LAST)) u_min (
    .clk(clk),
    .rstn(rstn),
    .step(sec_carry),
    .load(time_load),
    .load_val(time_load_val.min),
    .count(time_now.min),
    .carry(min_carry)
  );

  wclk_wrap_counter #(.W(5), .LAST(HOUR_LAST)) u_hour (
    .clk(clk),
    .rstn(rstn),
    .step(min_carry),
    .load(time_load),
    .load_val(time_load_val.hour),
    .count(time_now.hour),
    .carry(hour_carry)
  );

  wclk_wrap_counter #(.W(15), .LAST(DAY_LAST)) u_day (
    .clk(clk),
    .rstn(rstn),
    .step(hour_carry),
    .load(time_load),
    .load_val(time_load_val.day),
    .count(time_now.day),
    .carry()
  );

  // ----------------------------------------------------------------
  // Write decode feeding the counters
  // ----------------------------------------------------------------
  // A write happens once address and data are both held and B is free
  logic wr_go;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign wr_go = s_q.aw_full && s_q.w_full && !s_q.bvalid;
  assign time_load = wr_go && (s_q.aw_addr[7:2] == OFS_TIME[7:2]);
  assign time_load_val = wclk_merge(time_now, s_q.w_data, s_q.w_strb);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (axil_req.araddr[7:2])
      OFS_CTRL[7:2]: rd_mux[EV_N-1:0] = s_q.ctrl;
      OFS_TIME[7:2]: rd_mux = time_now;
      OFS_ALARM_TOD[7:2]: rd_mux = s_q.alarm_tod;
      OFS_ALARM_DAY[7:2]: rd_mux = s_q.alarm_day;
      OFS_SWATCH[7:2]: rd_mux[SW_W-1:0] = s_q.sw_cnt;
      OFS_STATUS[7:2]: rd_mux[EV_N-1:0] = s_q.pending;
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state: bus, registers, events
  // ----------------------------------------------------------------
  logic [EV_N-1:0] ev;
  logic [EV_N-1:0] clr;
  logic tod_match, day_match, sw_under;

  always_comb begin
    s_d = s_q;
    clr = '0;

    // Address and data channels are taken independently, one each
    if (axil_req.awvalid && s_q.awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = axil_req.awaddr;
      s_d.awready = 1'b0;
    end
    if (axil_req.wvalid && s_q.wready) begin
      s_d.w_full = 1'b1;
      s_d.w_data = axil_req.wdata;
      s_d.w_strb = axil_req.wstrb;
      s_d.wready = 1'b0;
    end
    if (s_q.bvalid && axil_req.bready) begin
      s_d.bvalid = 1'b0;
    end

    // Register write
    if (wr_go) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_q.aw_addr[7:2])
        OFS_CTRL[7:2]: begin
          s_d.ctrl = EV_N'(wclk_merge(32'(s_q.ctrl), s_q.w_data, s_q.w_strb));
        end
        OFS_TIME[7:2]: begin
        end
        OFS_ALARM_TOD[7:2]: begin
          s_d.alarm_tod = wclk_merge(s_q.alarm_tod, s_q.w_data, s_q.w_strb);
        end
        OFS_ALARM_DAY[7:2]: begin
          s_d.alarm_day = wclk_merge(s_q.alarm_day, s_q.w_data, s_q.w_strb);
        end
        OFS_SWATCH[7:2]: begin
          // Loading the stopwatch also arms it for one underflow
          s_d.sw_cnt = SW_W'(wclk_merge(32'(s_q.sw_cnt), s_q.w_data, s_q.w_strb));
          s_d.sw_run = 1'b1;
        end
        OFS_STATUS[7:2]: begin
          clr = EV_N'(wclk_merge(32'h0000_0000, s_q.w_data, s_q.w_strb));
        end
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end

    // Read: one outstanding, data captured at the address handshake
    if (axil_req.arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_mux;
      s_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && axil_req.rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // Stopwatch countdown; underflow is the tick that finds zero
    sw_under = 1'b0;
    if (tick && s_q.sw_run && !(wr_go && s_q.aw_addr[7:2] == OFS_SWATCH[7:2])) begin
      if (s_q.sw_cnt == '0) begin
        sw_under = 1'b1;
        s_d.sw_run = 1'b0;
      end else begin
        s_d.sw_cnt = s_q.sw_cnt - SW_W'(1);
      end
    end

    // Alarms compare one cycle after the tick, when counters hold the new time
    s_d.tick_dly = tick;
    tod_match = (time_now.hour == s_q.alarm_tod.hour) &&
                (time_now.min == s_q.alarm_tod.min) &&
                (time_now.sec == s_q.alarm_tod.sec);
    day_match = (time_now == s_q.alarm_day);

    // Events, each gated by its own enable bit
    ev = '0;
    ev[EV_SEC] = tick;
    ev[EV_MIN] = sec_carry;
    ev[EV_HOUR] = min_carry;
    ev[EV_DAY] = hour_carry;
    ev[EV_ALM_TOD] = s_q.tick_dly && tod_match;
    ev[EV_ALM_DAY] = s_q.tick_dly && day_match;
    ev[EV_SWATCH] = sw_under;
    ev = ev & s_q.ctrl;

    // Sticky flags: a new event beats a clear in the same cycle
    s_d.pending = (s_q.pending & ~clr) | ev;

    // Interrupt and wakeup lines follow the enabled pending flags
    s_d.irq = |(s_q.pending & s_q.ctrl);
    s_d.wake = |(s_q.pending & s_q.ctrl);
    s_d.deep = |(s_q.pending & s_q.ctrl);
    s_d.regul = |(s_q.pending & s_q.ctrl);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.ctrl <= CTRL_RST;
      s_q.alarm_tod <= ALARM_RST;
      s_q.alarm_day <= ALARM_RST;
      s_q.pending <= STATUS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign axil_rsp.awready = s_q.awready;
  assign axil_rsp.wready = s_q.wready;
  assign axil_rsp.bvalid = s_q.bvalid;
  assign axil_rsp.bresp = s_q.bresp;
  assign axil_rsp.arready = s_q.arready;
  assign axil_rsp.rvalid = s_q.rvalid;
  assign axil_rsp.rdata = s_q.rdata;
  assign axil_rsp.rresp = s_q.rresp;
  // Power management gates wake_req per peripheral on its side
  assign irq = s_q.irq;
  assign wake_req = s_q.wake;
  assign deep_sleep_exit = s_q.deep;
  assign regulator_wake = s_q.regul;

endmodule

/* File: tb/wclk_top_sva.sv */
// Checker for the watch clock top: bus handshakes, wake fan-out, sticky irq.
// Assumes it is bound to wclk_top and sees only its ports.

`timescale 1ns/10ps

module wclk_top_sva
  import wclk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire wclk_axil_req_type axil_req,
  input wire wclk_axil_rsp_type axil_rsp,
  // Interrupt and wakeup
  input wire logic irq,
  input wire logic wake_req,
  input wire logic deep_sleep_exit,
  input wire logic regulator_wake
);
  // ----------------------------------------------------------------
  // Helper: cycles since the last write data handshake
  // ----------------------------------------------------------------
  logic [3:0] w_age_q;

  // Saturates so that old writes cannot excuse a falling irq
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      w_age_q <= 4'hF;
    end else if (axil_req.wvalid && axil_rsp.wready) begin
      w_age_q <= 4'h0;
    end else if (w_age_q != 4'hF) begin
      w_age_q <= w_age_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wake_follows_irq: assert property (@(posedge clk) disable iff (!rstn)
    wake_req == irq) else $error("wake request differs from irq");
  a_wake_fan_out: assert property (@(posedge clk) disable iff (!rstn)
    deep_sleep_exit == wake_req && regulator_wake == wake_req)
    else $error("wake fan-out differs from wake request");
  a_irq_sticky: assert property (@(posedge clk) disable iff (!rstn)
    $fell(irq) |-> w_age_q <= 4'h4) else $error("irq dropped without a write");
  a_write_answer: assert property (@(posedge clk) disable iff (!rstn)
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
    |-> ##[2:3] axil_rsp.bvalid) else $error("write response missing");
  a_read_answer: assert property (@(posedge clk) disable iff (!rstn)
    axil_req.arvalid && axil_rsp.arready |-> ##[1:2] axil_rsp.rvalid)
    else $error("read data missing");
  a_bresp_holds: assert property (@(posedge clk) disable iff (!rstn)
    axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (@(posedge clk) disable iff (!rstn)
    axil_rsp.rvalid && !axil_req.rready |=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
    else $error("read data dropped early");
  a_ar_blocked: assert property (@(posedge clk) disable iff (!rstn)
    axil_rsp.rvalid |-> !axil_rsp.arready) else $error("read accepted while busy");
  a_slverr_zero: assert property (@(posedge clk) disable iff (!rstn)
    axil_rsp.rvalid && axil_rsp.rresp == RESP_SLVERR |-> axil_rsp.rdata == 32'h0)
    else $error("refused read returned data");
endmodule

bind wclk_top wclk_top_sva u_sva (
  .clk(clk),
  .rstn(rstn),
  .axil_req(axil_req),
  .axil_rsp(axil_rsp),
  .irq(irq),
  .wake_req(wake_req),
  .deep_sleep_exit(deep_sleep_exit),
  .regulator_wake(regulator_wake)
);

/* File: tb/wclk_host_model.sv */
// Model of the processor side: per-peripheral wake gate and power-up path.
// Assumes the wake levels of the clock block arrive on clk.

`timescale 1ns/10ps

module wclk_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // From the clock block
  input wire logic irq,
  input wire logic wake_req,
  input wire logic deep_sleep_exit,
  input wire logic regulator_wake,
  // Software wake enable for this peripheral
  input wire logic wake_en,
  // Results
  output logic core_wake,
  output logic power_up
);
  // Core wakes only when software allowed this source; power-up is ungated
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_wake <= 1'b0;
      power_up <= 1'b0;
    end else begin
      core_wake <= wake_req & wake_en & irq;
      power_up <= deep_sleep_exit | regulator_wake;
    end
  end
endmodule

/* File: tb/wclk_top_tb.sv */
// Self-checking bench of the watch clock top with a shortened prescaler.
// Assumes the crystal is modelled as a level toggling every 4 clk cycles.

`timescale 1ns/10ps

module wclk_top_tb;
  import wclk_pkg::*;
  localparam int unsigned PRE = 4;
  localparam int TICK = PRE * 8;
  logic clk, rstn, xtal_in, wake_en, irq, wake_req, deep_exit, reg_wake;
  logic core_wake, power_up;
  logic [1:0] xcnt;
  wclk_axil_req_type req;
  wclk_axil_rsp_type rsp;
  int errors, tests_run, cyc, t0, n;
  logic [31:0] d;
  logic [1:0] r;

  wclk_top #(.PRESCALE(PRE), .SW_W(SWATCH_W)) dut (.clk(clk), .rstn(rstn),
    .xtal_in(xtal_in), .axil_req(req), .axil_rsp(rsp), .irq(irq),
    .wake_req(wake_req), .deep_sleep_exit(deep_exit), .regulator_wake(reg_wake));
  wclk_host_model u_host (.clk(clk), .rstn(rstn), .irq(irq), .wake_req(wake_req),
    .deep_sleep_exit(deep_exit), .regulator_wake(reg_wake), .wake_en(wake_en),
    .core_wake(core_wake), .power_up(power_up));

  // ----------------------------------------------------------------
  // Clock, crystal and cycle count
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Crystal period of 8 clk keeps it slower than clk/4
  always @(posedge clk) begin
    cyc <= cyc + 1;
    xcnt <= xcnt + 2'h1;
    if (xcnt == 2'h3) begin
      xtal_in <= ~xtal_in;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_p && rsp.awready === 1'b1) begin
        aw_p = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w_p && rsp.wready === 1'b1) begin
        w_p = 1'b0;
        req.wvalid <= 1'b0;
      end
    end while (aw_p || w_p);
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    check(rsp.bresp === er, "write response code");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Lets a cleared irq settle first, then waits a bounded time
  task automatic wait_irq(input int lim);
    repeat (2) @(posedge clk);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(irq === 1'b1, "irq not raised in time");
  endtask

  function automatic logic [31:0] tm(input logic [14:0] dy, input logic [4:0] h,
                                     input logic [5:0] m, input logic [5:0] s);
    return {dy, h, m, s};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(OFS_CTRL, d, r);
    check(d === 32'h0 && r === RESP_OKAY, "control after reset");
    rd(OFS_TIME, d, r);
    check(d === TIME_RST, "time after reset");
    rd(OFS_STATUS, d, r);
    check(d === 32'h0, "status after reset");
    rd(8'h18, d, r);
    check(d === 32'h0 && r === RESP_SLVERR, "unmapped read");
    wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask

  // Every counter wraps on one tick, day wraps from its last value
  task automatic t_rollover();
    wake_en <= 1'b1;
    wr(OFS_CTRL, 32'h0000_000E, RESP_OKAY);
    wr(OFS_TIME, tm(15'h7FFF, 5'h17, 6'h3B, 6'h3B), RESP_OKAY);
    wait_irq(3 * TICK);
    rd(OFS_STATUS, d, r);
    check(d[6:0] === 7'h0E, "minute, hour and day events");
    rd(OFS_TIME, d, r);
    check(d === tm(15'h0, 5'h0, 6'h0, 6'h0), "full wrap to zero");
    check(wake_req === 1'b1 && deep_exit === 1'b1, "wake outputs");
    check(reg_wake === 1'b1 && core_wake === 1'b1, "regulator and core wake");
    check(power_up === 1'b1, "power-up request at host");
    wake_en <= 1'b0;
    repeat (2) @(posedge clk);
    check(core_wake === 1'b0, "wake gated by host");
    wr(OFS_STATUS, 32'h0000_007F, RESP_OKAY);
    repeat (3) @(posedge clk);
    check(irq === 1'b0, "irq after clear");
  endtask

  // Spacing of two second events equals one prescaled period; timing starts
  // from a wait that began well before its tick, so detection is exact
  task automatic t_second();
    wr(OFS_CTRL, 32'h1 << EV_SEC, RESP_OKAY);
    wait_irq(2 * TICK);
    wr(OFS_STATUS, 32'h0000_007F, RESP_OKAY);
    wait_irq(2 * TICK);
    t0 = cyc;
    wr(OFS_STATUS, 32'h0000_007F, RESP_OKAY);
    wait_irq(2 * TICK);
    check(cyc - t0 === TICK, "tick spacing");
  endtask

  task automatic t_alarm();
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    wr(OFS_ALARM_TOD, tm(15'h9, 5'h0, 6'h0, 6'h2), RESP_OKAY);
    wr(OFS_TIME, tm(15'h3, 5'h0, 6'h0, 6'h0), RESP_OKAY);
    wr(OFS_STATUS, 32'h0000_007F, RESP_OKAY);
    wr(OFS_CTRL, 32'h1 << EV_ALM_TOD, RESP_OKAY);
    wait_irq(4 * TICK);
    rd(OFS_STATUS, d, r);
    check(d[6:0] === 7'h10, "time-of-day alarm");
    rd(OFS_TIME, d, r);
    check(d === tm(15'h3, 5'h0, 6'h0, 6'h2), "alarm time ignores day");
    wr(OFS_ALARM_DAY, tm(15'h4, 5'h0, 6'h0, 6'h4), RESP_OKAY);
    wr(OFS_CTRL, 32'h1 << EV_ALM_DAY, RESP_OKAY);
    wr(OFS_STATUS, 32'h0000_007F, RESP_OKAY);
    repeat (4 * TICK) @(posedge clk);
    rd(OFS_STATUS, d, r);
    check(d[EV_ALM_DAY] === 1'b0, "day alarm on wrong day");
    wr(OFS_TIME, tm(15'h4, 5'h0, 6'h0, 6'h2), RESP_OKAY);
    wait_irq(4 * TICK);
    rd(OFS_STATUS, d, r);
    check(d[6:0] === 7'h20, "day and time alarm");
  endtask

  // Load 3: underflow on the fourth tick after load
  task automatic t_swatch();
    wr(OFS_CTRL, 32'h1 << EV_SWATCH, RESP_OKAY);
    wr(OFS_STATUS, 32'h0000_007F, RESP_OKAY);
    wr(OFS_SWATCH, 32'h0000_0003, RESP_OKAY);
    t0 = cyc;
    wait_irq(6 * TICK);
    check(cyc - t0 >= 3 * TICK && cyc - t0 <= 4 * TICK + 8, "underflow time");
    rd(OFS_SWATCH, d, r);
    check(d[15:0] === 16'h0, "stopwatch stopped at zero");
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    repeat (3) @(posedge clk);
    check(irq === 1'b0, "masked flag no longer drives irq");
    rd(OFS_STATUS, d, r);
    check(d[EV_SWATCH] === 1'b1, "flag stays pending");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    xtal_in = 1'b0;
    xcnt = 2'h0;
    wake_en = 1'b0;
    req = '0;
    cyc = 0;
    errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_rollover();
    t_second();
    t_alarm();
    t_swatch();
    finish_test();
  end

  // Run needs about 530 cycles; far beyond that means a hang
  initial begin
    #100us;
    errors++;
    $display("ERROR %0t: watchdog timeout", $time);
    finish_test();
  end
endmodule
